// >>> logic/lbds_consts.svh
// Offsets, field positions, codes and timing counts of the loopback diagnostic block
`ifndef LBDS_CONSTS_SVH
`define LBDS_CONSTS_SVH
`define LBDS_CLK_HZ          40000000
`define LBDS_BIT_HZ          10000000
`define LBDS_BIT_DIV         (`LBDS_CLK_HZ / `LBDS_BIT_HZ)
`define LBDS_HB_WINDOW_BITS  8'h40
`define LBDS_TC_CRC_INHIBIT  0
`define LBDS_TC_LB_LSB       1
`define LBDS_LB_NORMAL       2'h0
`define LBDS_LB_INTERNAL     2'h1
`define LBDS_LB_ENDEC        2'h2
`define LBDS_LB_XCVR         2'h3
`define LBDS_TS_SENT         0
`define LBDS_TS_DONE         1
`define LBDS_TS_COLLIDED     2
`define LBDS_TS_ABORTED      3
`define LBDS_TS_CARRIER_LOST 4
`define LBDS_TS_HEARTBEAT    6
`define LBDS_RS_INTACT       0
`define LBDS_RS_CRC_ERR      1
`define LBDS_RS_ALIGN_ERR    2
`define LBDS_RS_MULTICAST    5
`define LBDS_IS_RECEIVED     0
`define LBDS_IS_SENT         1
`define LBDS_IS_TX_ERROR     3
`define LBDS_PREAMBLE_BYTE   8'h55
`define LBDS_SYNC_BYTE       8'hD5
`define LBDS_PREAMBLE_BYTES  3'h7
`define LBDS_ADDR_BYTES      16'h0006
`define LBDS_CRC_INIT        32'hFFFFFFFF
`define LBDS_CRC_POLY        32'hEDB88320
`define LBDS_CRC_RESIDUE     32'hDEBB20E3
`endif

// >>> logic/lbds_loopback.sv
// Loopback transmit/receive path with transmit, receive and interrupt status
`timescale 1ns/1ps
`include "lbds_consts.svh"

// Summary of operation
// R1 - Internal loopback blocks carrier and collision, so carrier-lost and heartbeat flags set.
// R2 - Transmitter-appended CRC forces receiver CRC error, since one CRC engine is shared.
// R3 - Loopback sets only the packet-sent interrupt flag; packet-received stays 0.
// R4 - Encoder/decoder loopback: heartbeat flag set, carrier-lost clear; status 43/02/02.
// R5 - Transceiver loopback: no heartbeat or carrier-lost; status 03, or 01/07 variants.
// R6 - Transceiver loopback reports interrupt status 08 when the packet cannot be sent.
// R7 - External loopback still defers to carrier and stops on collision.
// R8 - Software must not trust receive data or status after live external loopback.
// R9 - CRC and alignment error flags only set for address-matching packets.
// R10 - Software runs address tests in internal loopback with its own CRC.
// R11 - Address tests use data config 40, transmit config 03, software CRC.
// R12 - Match with good CRC gives receive status 01, or 21 if multicast.
// R13 - Match with bad CRC gives receive status 02, or 22 if multicast.
// R14 - Non-matching address with bad CRC leaves receive status 01, no CRC flag.
// R15 - Internal loopback disables serial data and transmit enable outputs.
// R16 - Encoder/decoder loopback drives loopback output; heartbeat reported missing.
// R17 - Transceiver loopback needs real network access; later packets may overwrite results.
// R18 - CRC inhibit sends last FIFO byte last; otherwise four CRC bytes appended.
// R19 - Software writes zero then loopback mode between consecutive loopback sends.
// R20 - Transmit sends 56 preamble bits then an 8-bit sync pattern.
// R21 - At receive end the byte count bytes are written into the receive FIFO.
// R22 - Two-bit loopback field takes effect on the next transmit command; LOOPBACK_OUT_O follows the field one clock after it changes.
module lbds_loopback #(
  parameter int BIT_DIV        = `LBDS_BIT_DIV,
  parameter logic [7:0] HB_WIN = `LBDS_HB_WINDOW_BITS
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic [7:0]  TRANSMIT_CONFIG_I,
  input  wire logic        START_TX_I,
  input  wire logic [7:0]  TX_BYTE_I,
  input  wire logic        TX_BYTE_VALID_I,
  input  wire logic        TX_BYTE_LAST_I,
  input  wire logic [47:0] STATION_ADDR_I,
  input  wire logic        ACCEPT_MULTICAST_I,
  input  wire logic        CARRIER_SENSE_I,
  input  wire logic        COLLISION_I,
  input  wire logic        RX_DATA_I,
  output logic             TX_DATA_O,
  output logic             TX_ENABLE_OUT_O,
  output logic             LOOPBACK_OUT_O,
  output logic             TX_BYTE_TAKE_O,
  output logic             TX_BUSY_O,
  output logic [7:0]       RX_FIFO_DATA_O,
  output logic             RX_FIFO_WRITE_O,
  output logic [7:0]       TRANSMIT_STATUS_O,
  output logic [7:0]       RECEIVE_STATUS_O,
  output logic [7:0]       INTERRUPT_STATUS_O
);
  typedef struct packed {
    logic [7:0]                 div;
    lbds_pkg::lbds_tx_state_type tx;
    logic [1:0]                 lb;
    logic                       inh;
    logic [4:0]                 bcnt;
    logic [2:0]                 pidx;
    logic [7:0]                 sh;
    logic                       last;
    logic [31:0]                crc;
    logic                       cs_seen;
    logic                       hb_seen;
    logic [7:0]                 hb_cnt;
    logic [7:0]                 transmit_status;
    logic [7:0]                 interrupt_status;
    logic                       txd;
    logic                       tx_enable_out;
    logic                       loopback_out;
    logic                       take;
    logic                       busy;
    logic                       cs1, cs2, col1, col2, rxd1, rxd2;
    lbds_pkg::lbds_rx_state_type rx;
    logic [7:0]                 rsh;
    logic [2:0]                 rbits;
    logic [15:0]                rcount;
    logic                       phys_ok;
    logic                       mc;
    logic [7:0]                 receive_status;
    logic [7:0]                 fdata;
    logic                       fwe;
    logic [1:0]                 post;
    logic                       frame_d;
  } lbds_state_type;

  lbds_state_type s;
  lbds_state_type next_s;

  always_comb
  begin
    logic       bit_en;
    logic       ext;
    logic       tx_on;
    logic       tx_bit;
    logic       rbit;
    logic       frame;
    logic [7:0] rbyte;
    logic       crc_bad;
    logic       match;
    bit_en  = (s.div == 8'h00);
    ext     = (s.lb != `LBDS_LB_INTERNAL);
    tx_on   = (s.tx == lbds_pkg::TX_PREAMBLE) || (s.tx == lbds_pkg::TX_DATA) || (s.tx == lbds_pkg::TX_CRC);
    tx_bit  = (s.tx == lbds_pkg::TX_CRC) ? ~s.crc[0] : s.sh[0];
    rbit    = ext ? s.rxd2 : tx_bit;
    frame   = ext ? s.cs2 : tx_on;
    rbyte   = {rbit, s.rsh[7:1]};
    crc_bad = 1'b0;
    match   = 1'b0;
    next_s  = s;
    next_s.div  = bit_en ? 8'(BIT_DIV - 1) : s.div - 8'h01;
    next_s.cs1  = CARRIER_SENSE_I;
    next_s.cs2  = s.cs1;
    next_s.col1 = COLLISION_I;
    next_s.col2 = s.col1;
    next_s.rxd1 = RX_DATA_I;
    next_s.rxd2 = s.rxd1;
    next_s.take = 1'b0;
    next_s.fwe  = 1'b0;
    // R16 loopback pin
    next_s.loopback_out = (TRANSMIT_CONFIG_I[`LBDS_TC_LB_LSB +: 2] == `LBDS_LB_ENDEC);

    case (s.tx)
      lbds_pkg::TX_IDLE:
      begin
        if (START_TX_I)
        begin
          // R22 latch path
          next_s.lb      = TRANSMIT_CONFIG_I[`LBDS_TC_LB_LSB +: 2];
          next_s.inh     = TRANSMIT_CONFIG_I[`LBDS_TC_CRC_INHIBIT];
          next_s.transmit_status     = 8'h00;
          next_s.interrupt_status     = 8'h00;
          next_s.cs_seen = 1'b0;
          next_s.hb_seen = 1'b0;
          next_s.tx      = lbds_pkg::TX_DEFER;
        end
      end
      lbds_pkg::TX_DEFER:
      begin
        // R7 defer to carrier
        if (bit_en && !(ext && s.cs2))
        begin
          next_s.tx   = lbds_pkg::TX_PREAMBLE;
          next_s.sh   = `LBDS_PREAMBLE_BYTE;
          next_s.pidx = 3'h0;
          next_s.bcnt = 5'h00;
          next_s.last = 1'b0;
          if (!s.inh)
            next_s.crc = `LBDS_CRC_INIT;
        end
      end
      lbds_pkg::TX_PREAMBLE, lbds_pkg::TX_DATA, lbds_pkg::TX_CRC:
      begin
        if (bit_en)
        begin
          next_s.bcnt = s.bcnt + 5'h01;
          next_s.sh   = {1'b0, s.sh[7:1]};
          // R1 blocked when internal
          if (ext && s.cs2)
            next_s.cs_seen = 1'b1;
          if (s.tx == lbds_pkg::TX_CRC)
          begin
            next_s.crc = {1'b0, s.crc[31:1]};
            if (s.bcnt == 5'h1F)
            begin
              next_s.tx     = lbds_pkg::TX_HEARTBEAT;
              next_s.hb_cnt = HB_WIN;
            end
          end
          else
          begin
            // R2 shared CRC engine
            if (s.tx == lbds_pkg::TX_DATA && !s.inh)
              next_s.crc = {1'b0, s.crc[31:1]} ^ ((s.crc[0] ^ tx_bit) ? `LBDS_CRC_POLY : 32'h00000000);
            if (s.bcnt[2:0] == 3'h7)
            begin
              next_s.bcnt = 5'h00;
              // R20 preamble then sync
              if (s.tx == lbds_pkg::TX_PREAMBLE && s.pidx != `LBDS_PREAMBLE_BYTES)
              begin
                next_s.pidx = s.pidx + 3'h1;
                next_s.sh   = (s.pidx == 3'h6) ? `LBDS_SYNC_BYTE : `LBDS_PREAMBLE_BYTE;
              end
              else if (!s.last && TX_BYTE_VALID_I)
              begin
                next_s.tx   = lbds_pkg::TX_DATA;
                next_s.sh   = TX_BYTE_I;
                next_s.last = TX_BYTE_LAST_I;
                next_s.take = 1'b1;
              end
              // R18 CRC inhibit choice
              else if (!s.inh)
                next_s.tx = lbds_pkg::TX_CRC;
              else
              begin
                next_s.tx     = lbds_pkg::TX_HEARTBEAT;
                next_s.hb_cnt = HB_WIN;
              end
            end
          end
          // R7 R17 collision stops attempt
          if (ext && s.col2)
          begin
            next_s.tx                      = lbds_pkg::TX_IDLE;
            next_s.transmit_status                     = 8'h00;
            next_s.transmit_status[`LBDS_TS_COLLIDED]  = 1'b1;
            next_s.transmit_status[`LBDS_TS_ABORTED]   = 1'b1;
            // R6 not transmittable
            next_s.interrupt_status[`LBDS_IS_TX_ERROR]  = 1'b1;
          end
        end
      end
      lbds_pkg::TX_HEARTBEAT:
      begin
        // R16 heartbeat only from outside
        if (ext && s.col2)
          next_s.hb_seen = 1'b1;
        if (bit_en)
        begin
          next_s.hb_cnt = s.hb_cnt - 8'h01;
          if (s.hb_cnt == 8'h00)
          begin
            next_s.tx                          = lbds_pkg::TX_IDLE;
            next_s.transmit_status[`LBDS_TS_SENT]          = 1'b1;
            next_s.transmit_status[`LBDS_TS_DONE]          = 1'b1;
            // R1 R4 R5 carrier and heartbeat
            next_s.transmit_status[`LBDS_TS_CARRIER_LOST]  = !s.cs_seen;
            next_s.transmit_status[`LBDS_TS_HEARTBEAT]     = !s.hb_seen;
            // R3 only packet-sent flag
            next_s.interrupt_status[`LBDS_IS_SENT]          = 1'b1;
          end
        end
      end
      default:
        next_s.tx = lbds_pkg::TX_IDLE;
    endcase

    // R15 internal keeps pins quiet
    // Pins move on bit ticks only, so the last bit also stands a full bit time
    next_s.tx_enable_out  = (next_s.tx == lbds_pkg::TX_IDLE) ? 1'b0 : (bit_en ? (tx_on && ext) : s.tx_enable_out);
    next_s.txd  = next_s.tx_enable_out && (bit_en ? tx_bit : s.txd);
    next_s.busy = (next_s.tx != lbds_pkg::TX_IDLE);

    if (bit_en)
      next_s.frame_d = frame;
    case (s.rx)
      lbds_pkg::RX_HUNT:
      begin
        if (bit_en && frame)
        begin
          next_s.rsh = rbyte;
          if (rbyte == `LBDS_SYNC_BYTE)
          begin
            next_s.rx      = lbds_pkg::RX_DATA;
            next_s.rbits   = 3'h0;
            next_s.rcount  = 16'h0000;
            next_s.phys_ok = 1'b1;
            next_s.mc      = 1'b0;
            if (s.inh)
              next_s.crc = `LBDS_CRC_INIT;
          end
        end
        else if (bit_en)
          next_s.rsh = 8'h00;
      end
      lbds_pkg::RX_DATA:
      begin
        if (bit_en && frame)
        begin
          next_s.rsh   = rbyte;
          next_s.rbits = s.rbits + 3'h1;
          // R2 receiver checks only software CRC
          if (s.inh)
            next_s.crc = {1'b0, s.crc[31:1]} ^ ((s.crc[0] ^ rbit) ? `LBDS_CRC_POLY : 32'h00000000);
          if (s.rbits == 3'h7)
          begin
            next_s.fdata  = rbyte;
            next_s.fwe    = 1'b1;
            next_s.rcount = s.rcount + 16'h0001;
            if (s.rcount < `LBDS_ADDR_BYTES)
            begin
              if (rbyte != STATION_ADDR_I[8 * s.rcount[2:0] +: 8])
                next_s.phys_ok = 1'b0;
              if (s.rcount == 16'h0000)
                next_s.mc = rbyte[0];
            end
          end
        end
        else if (bit_en && s.frame_d)
        begin
          crc_bad = s.inh ? (s.crc != `LBDS_CRC_RESIDUE) : 1'b1;
          match   = (s.phys_ok && !s.mc) || (s.mc && ACCEPT_MULTICAST_I);
          next_s.receive_status = 8'h00;
          // R9 R12 R13 R14 status by address match
          if (match && s.rcount >= `LBDS_ADDR_BYTES)
          begin
            next_s.receive_status[`LBDS_RS_CRC_ERR]   = crc_bad;
            next_s.receive_status[`LBDS_RS_ALIGN_ERR] = crc_bad && (s.rbits != 3'h0);
            next_s.receive_status[`LBDS_RS_INTACT]    = !crc_bad;
            next_s.receive_status[`LBDS_RS_MULTICAST] = s.mc;
          end
          else
            next_s.receive_status[`LBDS_RS_INTACT] = 1'b1;
          // R3 received flag only outside loopback
          if (s.lb == `LBDS_LB_NORMAL)
            next_s.interrupt_status[`LBDS_IS_RECEIVED] = 1'b1;
          next_s.rx   = lbds_pkg::RX_COUNT;
          next_s.post = 2'h0;
        end
      end
      lbds_pkg::RX_COUNT:
      begin
        // R21 count bytes low, high, low
        next_s.fwe   = 1'b1;
        next_s.fdata = (s.post == 2'h1) ? s.rcount[15:8] : s.rcount[7:0];
        next_s.post  = s.post + 2'h1;
        if (s.post == 2'h2)
          next_s.rx = lbds_pkg::RX_HUNT;
      end
      default:
        next_s.rx = lbds_pkg::RX_HUNT;
    endcase
    // Receive side may write the rx flag in the cycle a new start clears it
    if (START_TX_I && s.tx == lbds_pkg::TX_IDLE && next_s.interrupt_status[`LBDS_IS_RECEIVED] && !s.interrupt_status[`LBDS_IS_RECEIVED])
      next_s.interrupt_status[`LBDS_IS_RECEIVED] = 1'b1;
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      s    <= '0;
      s.tx <= lbds_pkg::TX_IDLE;
      s.rx <= lbds_pkg::RX_HUNT;
    end
    else
      s <= next_s;
  end

  assign TX_DATA_O          = s.txd;
  assign TX_ENABLE_OUT_O    = s.tx_enable_out;
  assign LOOPBACK_OUT_O     = s.loopback_out;
  assign TX_BYTE_TAKE_O     = s.take;
  assign TX_BUSY_O          = s.busy;
  assign RX_FIFO_DATA_O     = s.fdata;
  assign RX_FIFO_WRITE_O    = s.fwe;
  assign TRANSMIT_STATUS_O  = s.transmit_status;
  assign RECEIVE_STATUS_O   = s.receive_status;
  assign INTERRUPT_STATUS_O = s.interrupt_status;
endmodule

// >>> logic/lbds_pkg.sv
// State types of the loopback diagnostic block
package lbds_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_DEFER, TX_PREAMBLE, TX_DATA, TX_CRC, TX_HEARTBEAT} lbds_tx_state_type;
  typedef enum logic [1:0] {RX_HUNT, RX_DATA, RX_COUNT} lbds_rx_state_type;
endpackage

// >>> verification/lbds_far_end.sv
// Behavioural encoder/decoder and transceiver on the serial side
`timescale 1ns/1ps
module lbds_far_end (
  input  wire logic clk_i,
  input  wire logic tx_data_i,
  input  wire logic tx_enable_i,
  input  wire logic loopback_i,
  input  wire logic net_busy_i,
  input  wire logic jam_i,
  output logic      carrier_o,
  output logic      collision_o,
  output logic      rx_data_o
);
  logic filler = 1'b0;
  logic was_en = 1'b0;
  int   hb_count = 0;
  always @(posedge clk_i)
  begin
    filler <= !filler;
    was_en <= tx_enable_i;
    if (was_en && !tx_enable_i && !loopback_i)
      hb_count <= 12;
    else if (hb_count > 0)
      hb_count <= hb_count - 1;
  end
  assign carrier_o   = tx_enable_i || net_busy_i;
  assign collision_o = (jam_i && tx_enable_i) || (hb_count > 0 && hb_count < 9);
  // Released line toggles so stale data is never mistaken for a frame
  assign rx_data_o   = tx_enable_i ? tx_data_i : filler;
endmodule

// >>> verification/lbds_loopback_checker.sv
// Port-level assertions for the loopback diagnostic block
`timescale 1ns/1ps
module lbds_checker (
  input wire logic       REF_CLK_I,
  input wire logic       RESET_I,
  input wire logic [7:0] TRANSMIT_CONFIG_I,
  input wire logic       START_TX_I,
  input wire logic       CARRIER_SENSE_I,
  input wire logic       TX_DATA_O,
  input wire logic       TX_ENABLE_OUT_O,
  input wire logic       LOOPBACK_OUT_O,
  input wire logic       TX_BUSY_O,
  input wire logic [7:0] TRANSMIT_STATUS_O,
  input wire logic [7:0] RECEIVE_STATUS_O,
  input wire logic [7:0] INTERRUPT_STATUS_O
);
  default clocking dc @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  wire logic [1:0] path = TRANSMIT_CONFIG_I[2:1];
  sequence s_take;
    START_TX_I && !TX_BUSY_O;
  endsequence
  sequence s_done;
    $fell(TX_BUSY_O);
  endsequence
  a_start_clears: assert property (s_take |=> TX_BUSY_O && TRANSMIT_STATUS_O == 8'h00)
    else $error("start not taken");
  a_int_quiet: assert property (path == 2'h1 && TX_BUSY_O |-> !TX_ENABLE_OUT_O && !TX_DATA_O)
    else $error("serial pins active in internal path");
  a_loopback_out_pin: assert property (1'b1 |=> LOOPBACK_OUT_O == $past(path == 2'h2))
    else $error("loopback pin wrong");
  a_int_status: assert property (s_done ##0 path == 2'h1
    |-> TRANSMIT_STATUS_O == 8'h53 && INTERRUPT_STATUS_O == 8'h02)
    else $error("internal path status wrong");
  a_endec_status: assert property (s_done ##0 path == 2'h2
    |-> TRANSMIT_STATUS_O == 8'h43 && INTERRUPT_STATUS_O == 8'h02)
    else $error("encoder path status wrong");
  a_xcvr_flags: assert property (s_done ##0 path == 2'h3
    |-> TRANSMIT_STATUS_O[6:4] == 3'h0 && (INTERRUPT_STATUS_O == 8'h02 || INTERRUPT_STATUS_O == 8'h08))
    else $error("transceiver path flags wrong");
  a_abort_isr: assert property (s_done ##0 TRANSMIT_STATUS_O[3] |-> INTERRUPT_STATUS_O == 8'h08)
    else $error("abort interrupt wrong");
  a_no_rx_flag: assert property (s_done ##0 path != 2'h0 |-> !INTERRUPT_STATUS_O[0])
    else $error("received flag set in loopback");
  a_crc_forced: assert property ($changed(RECEIVE_STATUS_O) && path == 2'h1 && !TRANSMIT_CONFIG_I[0]
    |-> RECEIVE_STATUS_O == 8'h02)
    else $error("forced crc error missing");
  a_preamble_head: assert property ($rose(TX_ENABLE_OUT_O) |-> TX_DATA_O [*4] ##1 !TX_DATA_O [*4])
    else $error("preamble start wrong");
  a_defer_carrier: assert property ($rose(TX_ENABLE_OUT_O) |-> !$past(CARRIER_SENSE_I, 2))
    else $error("sent over carrier");
endmodule

bind lbds_loopback lbds_checker chk (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
  .TRANSMIT_CONFIG_I(TRANSMIT_CONFIG_I), .START_TX_I(START_TX_I), .CARRIER_SENSE_I(CARRIER_SENSE_I),
  .TX_DATA_O(TX_DATA_O), .TX_ENABLE_OUT_O(TX_ENABLE_OUT_O), .LOOPBACK_OUT_O(LOOPBACK_OUT_O),
  .TX_BUSY_O(TX_BUSY_O), .TRANSMIT_STATUS_O(TRANSMIT_STATUS_O), .RECEIVE_STATUS_O(RECEIVE_STATUS_O),
  .INTERRUPT_STATUS_O(INTERRUPT_STATUS_O));

// >>> verification/tb_loopback_diag_status.sv
// Self-checking bench for the loopback diagnostic block
`timescale 1ns/1ps
module tb_loopback_diag_status;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  cfg = 8'h00;
  logic        start = 1'b0;
  logic [7:0]  pkt [0:23];
  int          len = 0;
  int          idx = 0;
  logic [47:0] addr = 48'h0;
  logic        mcast = 1'b0;
  logic        net_busy = 1'b0;
  logic        jam = 1'b0;
  logic        carrier_lost_flag, col, rxd, txd, tx_enable_out, loopback_out, take, busy, fwr;
  logic [7:0]  fdata, transmit_status, receive_status, interrupt_status;
  logic [7:0]  rxq [$];
  int          bad_count = 0;
  int          compares = 0;
  int          seed = 32'h7E44;
  int          n;
  int          kinds [5] = '{0, 0, 1, 1, 2};
  logic [7:0]  rs_exp [5] = '{8'h01, 8'h02, 8'h21, 8'h22, 8'h01};
  logic [7:0]  ts_exp [3] = '{8'h53, 8'h43, 8'h03};

  always #12.5 clk = ~clk;

  lbds_loopback #(.HB_WIN(8'h08)) uut (.REF_CLK_I(clk), .RESET_I(rst), .TRANSMIT_CONFIG_I(cfg),
    .START_TX_I(start), .TX_BYTE_I(pkt[idx]), .TX_BYTE_VALID_I(idx < len), .TX_BYTE_LAST_I(idx == len - 1),
    .STATION_ADDR_I(addr), .ACCEPT_MULTICAST_I(mcast), .CARRIER_SENSE_I(carrier_lost_flag), .COLLISION_I(col),
    .RX_DATA_I(rxd), .TX_DATA_O(txd), .TX_ENABLE_OUT_O(tx_enable_out), .LOOPBACK_OUT_O(loopback_out), .TX_BYTE_TAKE_O(take),
    .TX_BUSY_O(busy), .RX_FIFO_DATA_O(fdata), .RX_FIFO_WRITE_O(fwr), .TRANSMIT_STATUS_O(transmit_status),
    .RECEIVE_STATUS_O(receive_status), .INTERRUPT_STATUS_O(interrupt_status));

  lbds_far_end far (.clk_i(clk), .tx_data_i(txd), .tx_enable_i(tx_enable_out), .loopback_i(loopback_out),
    .net_busy_i(net_busy), .jam_i(jam), .carrier_o(carrier_lost_flag), .collision_o(col), .rx_data_o(rxd));

  always @(negedge clk)
    if (take)
      idx <= idx + 1;
  // Sampled mid-cycle, clear of the edge that launches the write
  always @(negedge clk)
    if (fwr)
      rxq.push_back(fdata);

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Software CRC, reflected, sent as complement low byte first
  task build(input int cnt, input int kind, input logic sw, input logic bad);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < cnt; i++)
      pkt[i] = (i < 6) ? addr[8*i +: 8] ^ ((kind == 1) ? 8'h01 : (kind == 2) ? 8'h80 : 8'h00) : 8'($random(seed));
    for (int i = 0; i < cnt; i++)
      for (int b = 0; b < 8; b++)
        c = (c >> 1) ^ ((c[0] ^ pkt[i][b]) ? 32'hEDB88320 : 32'h0);
    for (int i = 0; i < 4; i++)
      pkt[cnt + i] = ~c[8*i +: 8] ^ {7'h0, bad};
    len = sw ? cnt + 4 : cnt;
    mcast = (kind == 1);
  endtask

  task send(input logic [7:0] mode, input int defer_cyc, input int jam_at);
    int t;
    @(negedge clk);
    cfg = 8'h00;
    // Foreign carrier raised early so it has passed the synchronisers by the start
    net_busy = (defer_cyc > 0);
    @(negedge clk);
    cfg = mode;
    idx = 0;
    rxq.delete();
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    t = 0;
    while (busy !== 1'b0 && t < 20000)
    begin
      @(negedge clk);
      t++;
      net_busy = net_busy && (t < defer_cyc);
      jam = (jam_at > 0) && (t >= jam_at) && (t < jam_at + 8);
    end
    if (t >= 20000)
    begin
      bad_count++;
      print_verdict();
    end
  endtask

  // Received bytes, then count low, high, low
  task check_rx(input int cnt);
    int t;
    t = 0;
    while (rxq.size() < cnt + 3 && t < 2000)
    begin
      @(negedge clk);
      t++;
    end
    if (t >= 2000)
    begin
      bad_count++;
      print_verdict();
    end
    for (int i = 0; i < cnt; i++)
      check(rxq[i], pkt[i]);
    check(rxq[cnt], 8'(cnt));
    check(rxq[cnt + 1], 8'(cnt >> 8));
    check(rxq[cnt + 2], 8'(cnt));
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    addr = 48'({$random(seed), $random(seed)}) & 48'hFFFFFFFFFFFE;
    rst = 1'b0;
    for (int m = 0; m < 3; m++)
    begin
      n = 6 + ($random(seed) & 32'h7);
      build(n, 0, 1'b0, 1'b0);
      send(8'(2 * m + 2), 0, 0);
      check(transmit_status, ts_exp[m]);
      check(interrupt_status, 8'h02);
      check(receive_status, 8'h02);
      check_rx(n + 4);
    end
    for (int k = 0; k < 5; k++)
    begin
      n = 6 + ($random(seed) & 32'h7);
      build(n, kinds[k], 1'b1, k[0] ^ (k == 4));
      send(8'h03, 0, 0);
      check(receive_status, rs_exp[k]);
      check(transmit_status, 8'h53);
      check_rx(n + 4);
    end
    build(8, 0, 1'b0, 1'b0);
    send(8'h00, 0, 0);
    check(interrupt_status, 8'h03);
    check(transmit_status, 8'h03);
    // receive side not trusted on live network
    build(8, 0, 1'b0, 1'b0);
    send(8'h06, 200, 0);
    check(transmit_status, 8'h03);
    check(interrupt_status, 8'h02);
    build(8, 0, 1'b0, 1'b0);
    send(8'h06, 0, 100);
    check(transmit_status, 8'h0C);
    check(interrupt_status, 8'h08);
    print_verdict();
  end
endmodule
